// [bench/cid_decoder_props.sv]
/* port checks for cid_decoder: timing, pointer and flag relations.
   assumes one clock core_clk and synchronous active-high rst. */
`timescale 1ns/1ns
module cid_decoder_chk #(
    parameter PC_W = 15     // program counter width
) (
    // clock, reset and stream
    input wire            core_clk,
    input wire            rst,
    input wire            instrValid,
    input wire            instrReady,
    input wire [13:0]     instr,
    input wire [PC_W-1:0] pc,
    // memory and state
    input wire            memRead,
    input wire            zeroFlag,
    input wire            carryFlag,
    input wire [7:0]      memRdata,
    input wire [7:0]      w,
    input wire [15:0]     ptr0,
    input wire [15:0]     ptr1,
    // power control
    input wire            watchdogExpiredFlag,
    input wire            powerdownFlag,
    input wire            watchdogClear,
    input wire            idleOnSleep,
    input wire            idleEnter
);
// ****************************************************************
// assertions
// ****************************************************************
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
wire        tk   = instrValid && instrReady;    // word taken this edge
wire [15:0] selp = instr[2] ? ptr1 : ptr0;      // pointer named by n
sequence busy1; !instrReady ##1 instrReady; endsequence
ctrl_ready_a: assert property (tk && (instr[13:12] == 2'b10
    || instr[13:9] == 5'b11001 || instr[13:8] == 6'h34 || instr[13:2] == 12'h002)
    |=> busy1) else $error("ctrl timing");
rel_target_a: assert property (tk && instr[13:9] == 5'b11001 |=> pc ==
    PC_W'($past(pc) + 1 + {{(PC_W-9){$past(instr[8])}}, $past(instr[8:0])}))
    else $error("bad rel target");
load_data_a: assert property (tk && instr[13:3] == 11'h002 && !selp[15] |=> memRead
    ##1 (w == $past(memRdata) && zeroFlag == (w == 8'h00))) else $error("bad load");
store_pen_a: assert property (tk && instr[13:3] == 11'h003 && selp[15] |=> busy1)
    else $error("no store penalty");
sleep_flags_a: assert property (tk && instr == 14'h0063 |=> !powerdownFlag
    && watchdogClear && watchdogExpiredFlag && idleEnter == $past(idleOnSleep))
    else $error("bad sleep");
wdog_flags_a: assert property (tk && instr == 14'h0064 |=> powerdownFlag
    && watchdogExpiredFlag && watchdogClear) else $error("bad watchdog clear");
ptr_add_a: assert property (tk && instr[13:6] == 8'hC4 |=> $stable(zeroFlag)
    && ptr0 == 16'($past(ptr0) + {{10{$past(instr[5])}}, $past(instr[5:0])}))
    else $error("bad add");
lit_and_a: assert property (tk && instr[13:8] == 6'h39 |=> zeroFlag == (w == 8'h00)
    && w == ($past(w) & $past(instr[7:0])) && $stable(carryFlag))
    else $error("bad literal and");
lit_add_a: assert property (tk && instr[13:8] == 6'h3E |=> {carryFlag, w} ==
    $past(w) + $past(instr[7:0])) else $error("bad literal add");
endmodule
bind cid_decoder cid_decoder_chk #(.PC_W(PC_W)) chk_u (.*);

// [bench/testbench.sv]
/* self-checking bench for cid_decoder: words sent through the ready
   handshake, results compared. assumes memory answers at once. */
`timescale 1ns/1ns
module testbench;
// ****************************************************************
// signals, tasks and tests
// ****************************************************************
    reg         core_clk = 0, rst = 1, instrValid = 0, idleOnSleep = 1; // stimulus
    reg  [13:0] instr = 0;                   // word offered
    wire        instrReady, memRead, memWrite, zeroFlag, carryFlag, digitCarryFlag;
    wire        watchdogExpiredFlag, powerdownFlag, intEnable, standbyEnter, idleEnter;
    wire        watchdogClear, softReset, pinDirWrite;
    wire [14:0] pc;
    wire [15:0] memAddr, ptr0, ptr1;
    wire [7:0]  memWdata, w, pinDirData;
    wire [2:0]  pinDirSel;
    wire [7:0]  memRdata = memAddr[7:0] ^ 8'h5A; // pattern memory, no wait
    integer     n_fail = 0, check_count = 0, cyc = 0, cnt, i;
    reg  [15:0] p, np, a;                    // expected pointer work
    reg  [14:0] pc0;                         // pc at the taking edge
    reg  [25:0] c1;                          // memory port one cycle after take
    cid_decoder dut_u (.*);
    always #4 core_clk = ~core_clk;
    // hang guard: a count far above the run length
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    task chk(input [47:0] g, input [47:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    // valid stays high; word swaps in the same step as ready is seen
    task send(input [13:0] word);
        begin
            instr = word;
            pc0 = pc;
            @(posedge core_clk) #1;
            c1 = {memRead, memWrite, memAddr, memWdata};
            cnt = 0;
            while (instrReady !== 1'b1 && cnt < 9) begin
                @(posedge core_clk) #1;
                cnt = cnt + 1;
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1 rst = 0;
        instrValid = 1;
        chk({pc, powerdownFlag, watchdogExpiredFlag}, 17'h3);
        send(14'h3EF8);
        send(14'h3E18);
        chk({carryFlag, digitCarryFlag, w}, 10'h310);
        send(14'h390F);
        chk({carryFlag, zeroFlag, w}, 10'h300);
        $display("literal test done");
        send(14'h313F);
        chk(ptr0, 16'hFFFF);
        send(14'h315F);
        chk({zeroFlag, ptr1}, 17'h1001F);
        send(14'h0019);
        chk(c1, 26'h1FFFE00);
        chk(cnt, 1);
        send(14'h0012);
        chk({c1[25:8], w, ptr0}, 42'h2FFFEA4FFFF);
        chk(cnt, 2);
        p = 16'h001F;
        for (i = 0; i < 4; i = i + 1) begin
            np = i[0] ? p - 16'h1 : p + 16'h1;
            a = i[1] ? p : np;
            send({11'h002, 1'b1, i[1:0]});
            chk(c1[25:8], {2'b10, a});
            chk({ptr1, w}, {np, a[7:0] ^ 8'h5A});
            p = np;
        end
        send(14'h3F7E);
        chk({c1[25:8], ptr1, w}, 42'h2001D001F47);
        send(14'h3F82);
        chk({zeroFlag, c1}, 27'h1000147);
        send(14'h0590);
        chk({c1[25:8], memWrite, memAddr, memWdata}, {18'h20010, 1'b1, 16'h0010, 8'h42});
        chk(w, 8'h47);
        $display("pointer test done");
        send(14'h33FD);
        chk({cnt[0], pc}, {1'b1, pc0 - 15'h2});
        send(14'h2923);
        chk(pc, {pc0[14:11], 11'h123});
        send(14'h2456);
        p = pc0 + 16'h1;
        chk(pc, {pc0[14:11], 11'h456});
        send(14'h3477);
        chk({pc, w}, {p[14:0], 8'h77});
        send(14'h000B);
        chk(pc, pc0 + 15'h78);
        send(14'h000A);
        p = pc0 + 16'h1;
        chk(pc, {pc0[14:8], 8'h77});
        send(14'h0009);
        chk({intEnable, pc}, {1'b1, p[14:0]});
        send(14'h2456);
        p = pc0 + 16'h1;
        send(14'h0008);
        chk({cnt[0], pc}, {1'b1, p[14:0]});
        send(14'h2C56);
        chk({cnt[0], pc}, {1'b1, pc0[14:11], 11'h456});
        $display("control test done");
        send(14'h0063);
        chk({idleEnter, standbyEnter, powerdownFlag, watchdogExpiredFlag, watchdogClear},
            5'b10011);
        idleOnSleep = 0;
        send(14'h0063);
        chk({idleEnter, standbyEnter}, 2'b01);
        send(14'h0064);
        chk({powerdownFlag, watchdogExpiredFlag, watchdogClear}, 3'b111);
        send(14'h0065);
        chk({pinDirWrite, pinDirSel, pinDirData}, 12'hD77);
        send(14'h0000);
        chk({cnt[3:0], pc}, {4'h0, pc0 + 15'h1});
        send(14'h0001);
        chk({softReset, pc, w, ptr0}, 40'h8000000000);
        $display("system test done");
        close_out;
    end
endmodule

// [verilog/cid_consts.vh]
/*
 * constants for the control and indirect operation decoder: opcode
 * patterns, field positions, reset values and one-hot state codes.
 * assumes it is included by bare name from the decoder file only.
 */
`ifndef CID_CONSTS_VH
`define CID_CONSTS_VH

// ****************************************************************
// instruction word patterns (casez, ? marks operand bits)
// ****************************************************************
`define CID_OP_NOP        14'b00_0000_0000_0000
`define CID_OP_SWRESET    14'b00_0000_0000_0001
`define CID_OP_SUBEXIT    14'b00_0000_0000_1000
`define CID_OP_INTEXIT    14'b00_0000_0000_1001
`define CID_OP_CALL_BY_ACCUMULATOR      14'b00_0000_0000_1010
`define CID_OP_RELW       14'b00_0000_0000_1011
`define CID_OP_SLEEP      14'b00_0000_0110_0011
`define CID_OP_WDCLEAR    14'b00_0000_0110_0100
`define CID_OP_PINDIR     14'b00_0000_0110_0???
`define CID_OP_ILOAD      14'b00_0000_0001_0???
`define CID_OP_ISTORE     14'b00_0000_0001_1???
`define CID_OP_FILEAND    14'b00_0101_????_????
`define CID_OP_CALL       14'b10_0???_????_????
`define CID_OP_JUMP       14'b10_1???_????_????
`define CID_OP_RELJUMP    14'b11_001?_????_????
`define CID_OP_PTRADD     14'b11_0001_0???_????
`define CID_OP_EXITLIT    14'b11_0100_????_????
`define CID_OP_LITAND     14'b11_1001_????_????
`define CID_OP_LITADD     14'b11_1110_????_????
`define CID_OP_XLOAD      14'b11_1111_0???_????
`define CID_OP_XSTORE     14'b11_1111_1???_????

// ****************************************************************
// field positions
// ****************************************************************
`define CID_F_PTRSEL      6
`define CID_F_PTRSEL_MOD  2
`define CID_F_MMSEL       2
`define CID_F_DEST        7

// ****************************************************************
// pointer modifier codes
// ****************************************************************
`define CID_MM_PREINC     2'h0
`define CID_MM_PREDEC     2'h1
`define CID_MM_POSTINC    2'h2
`define CID_MM_POSTDEC    2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define CID_RST_PC        15'h0000
`define CID_RST_W         8'h00
`define CID_RST_PTR       16'h0000
`define CID_RST_TIMEOUT   1'b1
`define CID_RST_POWERDN   1'b1

// ****************************************************************
// one-hot sequencer states
// ****************************************************************
`define CID_ST_RUN        4'h1
`define CID_ST_READ       4'h2
`define CID_ST_NOP2       4'h4
`define CID_ST_PEN        4'h8

`endif

// [verilog/cid_decoder.v]
/*
 * control and indirect operation decoder: accepts 14-bit instruction
 * words, executes control flow, inherent, pointer and literal/file AND
 * and literal ADD operations, and drives a simple data memory port.
 * assumes instruction words and memory read data come from logic on
 * core_clk; memory read data is combinational on memAddr/memRead.
 */
`timescale 1ns/1ns
`include "cid_consts.vh"

module cid_decoder #(
    parameter PC_W        = 15,     // program counter width
    parameter STACK_DEPTH = 16      // return stack entries
) (
    // clock and reset
    input  wire              core_clk,
    input  wire              rst,
    // instruction stream
    input  wire [13:0]       instr,
    input  wire              instrValid,
    output reg               instrReady,
    output reg  [PC_W-1:0]   pc,
    // data memory port
    output reg  [15:0]       memAddr,
    output reg  [7:0]        memWdata,
    output reg               memRead,
    output reg               memWrite,
    input  wire [7:0]        memRdata,
    // architectural state
    output reg  [7:0]        w,
    output reg  [15:0]       ptr0,
    output reg  [15:0]       ptr1,
    output reg               zeroFlag,
    output reg               carryFlag,
    output reg               digitCarryFlag,
    output reg               watchdogExpiredFlag,
    output reg               powerdownFlag,
    output reg               intEnable,
    // power and system control
    input  wire              idleOnSleep,
    output reg               standbyEnter,
    output reg               idleEnter,
    output reg               watchdogClear,
    output reg               softReset,
    // pin direction register write
    output reg               pinDirWrite,
    output reg  [2:0]        pinDirSel,
    output reg  [7:0]        pinDirData
);

    // ****************************************************************
    // internal state
    // ****************************************************************
    localparam SP_W = $clog2(STACK_DEPTH);

    reg  [3:0]        state;                    // one-hot sequencer
    reg               pendPen;                  // extra cycle owed
    reg               pendFile;                 // read belongs to file and
    reg               pendDest;                 // file and destination bit
    reg  [PC_W-1:0]   stack [0:STACK_DEPTH-1];  // return addresses
    reg  [SP_W-1:0]   sp;                       // next free stack slot

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    wire              take     = instrReady & instrValid;
    // pointer select sits at bit 2 in the modifier forms, bit 6 in the rest
    wire              ptrSel   = instr[13] ? instr[`CID_F_PTRSEL] : instr[`CID_F_PTRSEL_MOD];
    wire [1:0]        mm       = instr[1:0];
    wire [15:0]       ptrCur   = ptrSel ? ptr1 : ptr0;
    wire [15:0]       lit6     = {{10{instr[5]}}, instr[5:0]};
    wire [PC_W-1:0]   pcInc    = pc + 1'b1;
    wire [PC_W-1:0]   relOff   = {{(PC_W-9){instr[8]}}, instr[8:0]};
    wire [PC_W-1:0]   spTop    = stack[sp - 1'b1];
    wire [8:0]        addSum   = {1'b0, w} + {1'b0, instr[7:0]};
    wire [4:0]        addLow   = {1'b0, w[3:0]} + {1'b0, instr[3:0]};
    wire [7:0]        litAnd   = w & instr[7:0];
    wire [7:0]        fileAnd  = w & memRdata;

    // ****************************************************************
    // pointer modifier: address used and value written back
    // ****************************************************************
    // 16-bit sums drop the carry out, giving the wrap; mm bit 0 picks
    // decrement, mm bit 1 presents the old pointer (post modes)
    wire [15:0]       modPtr   = mm[0] ? ptrCur - 16'h0001 : ptrCur + 16'h0001;
    wire [15:0]       modAddr  = mm[1] ? ptrCur : modPtr;
    // indexed address, same wrap as above
    wire [15:0]       idxAddr  = ptrCur + lit6;

    // ****************************************************************
    // main sequencer and execute
    // ****************************************************************
    // one process owns all architectural state so that a software reset
    // and an instruction can never fight over the same register
    always @(posedge core_clk) begin
        if (rst) begin
            state               <= `CID_ST_RUN;
            instrReady          <= 1'b1;
            pc                  <= `CID_RST_PC;
            w                   <= `CID_RST_W;
            ptr0                <= `CID_RST_PTR;
            ptr1                <= `CID_RST_PTR;
            zeroFlag            <= 1'b0;
            carryFlag           <= 1'b0;
            digitCarryFlag      <= 1'b0;
            watchdogExpiredFlag <= `CID_RST_TIMEOUT;
            powerdownFlag       <= `CID_RST_POWERDN;
            intEnable           <= 1'b0;
            sp                  <= {SP_W{1'b0}};
            pendPen             <= 1'b0;
            pendFile            <= 1'b0;
            pendDest            <= 1'b0;
            memAddr             <= 16'h0000;
            memWdata            <= 8'h00;
            memRead             <= 1'b0;
            memWrite            <= 1'b0;
            standbyEnter        <= 1'b0;
            idleEnter           <= 1'b0;
            watchdogClear       <= 1'b0;
            softReset           <= 1'b0;
            pinDirWrite         <= 1'b0;
            pinDirSel           <= 3'h0;
            pinDirData          <= 8'h00;
        end else begin
            // strobes last one cycle by default
            memRead       <= 1'b0;
            memWrite      <= 1'b0;
            standbyEnter  <= 1'b0;
            idleEnter     <= 1'b0;
            watchdogClear <= 1'b0;
            softReset     <= 1'b0;
            pinDirWrite   <= 1'b0;
            case (state)
                `CID_ST_RUN: begin
                    if (take) begin
                        pc <= pcInc;
                        casez (instr)
                            `CID_OP_NOP: begin
                                // nothing beyond the pc step
                            end
                            `CID_OP_SWRESET: begin
                                // restart from the reset vector; flags kept
                                softReset <= 1'b1;
                                pc        <= `CID_RST_PC;
                                w         <= `CID_RST_W;
                                ptr0      <= `CID_RST_PTR;
                                ptr1      <= `CID_RST_PTR;
                                sp        <= {SP_W{1'b0}};
                                intEnable <= 1'b0;
                            end
                            `CID_OP_SUBEXIT: begin
                                pc         <= spTop;
                                sp         <= sp - 1'b1;
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_INTEXIT: begin
                                pc         <= spTop;
                                sp         <= sp - 1'b1;
                                intEnable  <= 1'b1;
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_CALL_BY_ACCUMULATOR: begin
                                stack[sp]  <= pcInc;
                                sp         <= sp + 1'b1;
                                pc         <= {pc[PC_W-1:8], w};
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_RELW: begin
                                pc         <= pcInc + {{(PC_W-8){1'b0}}, w};
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_SLEEP: begin
                                // idle keeps peripherals running; standby stops all
                                standbyEnter        <= ~idleOnSleep;
                                idleEnter           <= idleOnSleep;
                                watchdogExpiredFlag <= 1'b1;
                                powerdownFlag       <= 1'b0;
                                watchdogClear       <= 1'b1;
                            end
                            `CID_OP_WDCLEAR: begin
                                watchdogClear       <= 1'b1;
                                watchdogExpiredFlag <= 1'b1;
                                powerdownFlag       <= 1'b1;
                            end
                            `CID_OP_PINDIR: begin
                                pinDirWrite <= 1'b1;
                                pinDirSel   <= instr[2:0];
                                pinDirData  <= w;
                            end
                            `CID_OP_ILOAD: begin
                                memAddr    <= modAddr;
                                memRead    <= 1'b1;
                                pendFile   <= 1'b0;
                                pendPen    <= ptrCur[15];
                                if (ptrSel) ptr1 <= modPtr;
                                else        ptr0 <= modPtr;
                                state      <= `CID_ST_READ;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_ISTORE: begin
                                memAddr  <= modAddr;
                                memWdata <= w;
                                memWrite <= 1'b1;
                                if (ptrSel) ptr1 <= modPtr;
                                else        ptr0 <= modPtr;
                                if (ptrCur[15]) begin
                                    state      <= `CID_ST_PEN;
                                    instrReady <= 1'b0;
                                end
                            end
                            `CID_OP_FILEAND: begin
                                memAddr    <= {9'h000, instr[6:0]};
                                memRead    <= 1'b1;
                                pendFile   <= 1'b1;
                                pendDest   <= instr[`CID_F_DEST];
                                pendPen    <= 1'b0;
                                state      <= `CID_ST_READ;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_CALL: begin
                                stack[sp]  <= pcInc;
                                sp         <= sp + 1'b1;
                                pc         <= {pc[PC_W-1:11], instr[10:0]};
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_JUMP: begin
                                pc         <= {pc[PC_W-1:11], instr[10:0]};
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_RELJUMP: begin
                                pc         <= pcInc + relOff;
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_PTRADD: begin
                                // no flag is touched here
                                if (ptrSel) ptr1 <= ptr1 + lit6;
                                else        ptr0 <= ptr0 + lit6;
                            end
                            `CID_OP_EXITLIT: begin
                                w          <= instr[7:0];
                                pc         <= spTop;
                                sp         <= sp - 1'b1;
                                state      <= `CID_ST_NOP2;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_LITAND: begin
                                w        <= litAnd;
                                zeroFlag <= (litAnd == 8'h00);
                            end
                            `CID_OP_LITADD: begin
                                w              <= addSum[7:0];
                                carryFlag      <= addSum[8];
                                digitCarryFlag <= addLow[4];
                                zeroFlag       <= (addSum[7:0] == 8'h00);
                            end
                            `CID_OP_XLOAD: begin
                                memAddr    <= idxAddr;
                                memRead    <= 1'b1;
                                pendFile   <= 1'b0;
                                pendPen    <= ptrCur[15];
                                state      <= `CID_ST_READ;
                                instrReady <= 1'b0;
                            end
                            `CID_OP_XSTORE: begin
                                memAddr  <= idxAddr;
                                memWdata <= w;
                                memWrite <= 1'b1;
                                if (ptrCur[15]) begin
                                    state      <= `CID_ST_PEN;
                                    instrReady <= 1'b0;
                                end
                            end
                            default: begin
                                // words owned by other decoders: pc step only
                            end
                        endcase
                    end
                end
                `CID_ST_READ: begin
                    // read data is valid now because memRead is high
                    if (pendFile) begin
                        zeroFlag <= (fileAnd == 8'h00);
                        if (pendDest) begin
                            memWdata <= fileAnd;
                            memWrite <= 1'b1;
                        end else begin
                            w <= fileAnd;
                        end
                    end else begin
                        w        <= memRdata;
                        zeroFlag <= (memRdata == 8'h00);
                    end
                    if (pendPen) begin
                        state <= `CID_ST_PEN;
                    end else begin
                        state      <= `CID_ST_RUN;
                        instrReady <= 1'b1;
                    end
                end
                `CID_ST_NOP2, `CID_ST_PEN: begin
                    // forced no-op while the new target is fetched
                    // or the extra cycle for the upper pointer space
                    state      <= `CID_ST_RUN;
                    instrReady <= 1'b1;
                end
                default: begin
                    state      <= `CID_ST_RUN;
                    instrReady <= 1'b1;
                end
            endcase
        end
    end

endmodule
